// ===== common/itrp_pkg.sv
package itrp_pkg;

  // ==========================================================================
  // Target address layout
  // ==========================================================================
  localparam logic [2:0] ITRP_ADDR_HI     = 3'h4;
  localparam logic [1:0] ITRP_ADDR_LO     = 2'h3;
  localparam logic       ITRP_DIR_READ    = 1'b1;

  // Strap decode: direct tie, 56k pull-up, 200k pull-up, ground.
  localparam logic [1:0] ITRP_STRAP_TIE   = 2'h0;
  localparam logic [1:0] ITRP_STRAP_56K   = 2'h1;
  localparam logic [1:0] ITRP_STRAP_200K  = 2'h2;
  localparam logic [1:0] ITRP_STRAP_GND   = 2'h3;

  // ==========================================================================
  // Register space
  // ==========================================================================
  localparam logic [7:0] ITRP_UNDEF_DATA  = 8'hFF;
  localparam logic [7:0] ITRP_OFFS_RESET  = 8'h00;
  localparam logic [7:0] ITRP_MAP_LAST    = 8'h16;
  localparam logic [3:0] ITRP_BIT_LAST    = 4'h7;
  localparam logic [3:0] ITRP_BIT_ACK     = 4'h8;

  typedef enum logic [2:0] {
    ITRP_IDLE   = 3'b000,
    ITRP_ADDR   = 3'b001,
    ITRP_OFFS   = 3'b011,
    ITRP_WDATA  = 3'b010,
    ITRP_RDATA  = 3'b110,
    ITRP_IGNORE = 3'b111
  } itrp_state_e;

endpackage

// ===== common/itrp_sync_if.sv
`timescale 1ns/1ps
interface itrp_sync_if;
  logic [1:0] raw;
  logic [1:0] sync;
  modport sync_side (input raw, output sync);
  modport user_side (output raw, input sync);
endinterface

// ===== core/itrp_sync.sv
`timescale 1ns/1ps
module itrp_sync (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  itrp_sync_if.sync_side   bus
);

  // Two flops per line; the first stage feeds only the second.
  logic [1:0] meta_ff;
  logic [1:0] sync_ff;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_ff <= 2'h3;
      sync_ff <= 2'h3;
    end else begin
      meta_ff <= bus.raw;
      sync_ff <= meta_ff;
    end
  end

  assign bus.sync = sync_ff;

endmodule

// ===== core/itrp_target.sv
`timescale 1ns/1ps
module itrp_target
  import itrp_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  input  wire logic [1:0] addr_strap_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic            wr_stb_o,
  output logic [7:0]      wr_offs_o,
  output logic [7:0]      wr_data_o,
  output logic [7:0]      rd_offs_o,
  input  wire logic [7:0] rd_data_i,
  output logic [6:0]      own_addr_o
);

  // ==========================================================================
  // Pin synchronisation and edge detection
  // ==========================================================================
  itrp_sync_if pins ();
  assign pins.raw = {scl_i, sda_i};

  itrp_sync u_sync (
    .clk_i  (clk_i),
    .nrst_i (nrst_i),
    .bus    (pins)
  );

  logic       scl_d_ff;
  logic       sda_d_ff;
  logic       scl_s;
  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;

  assign scl_s     = pins.sync[1];
  assign sda_s     = pins.sync[0];
  assign scl_rise  = scl_s & ~scl_d_ff;
  assign scl_fall  = ~scl_s & scl_d_ff;
  assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_d_ff <= 1'b1;
      sda_d_ff <= 1'b1;
    end else begin
      scl_d_ff <= scl_s;
      sda_d_ff <= sda_s;
    end
  end

  // ==========================================================================
  // Strap capture
  // ==========================================================================
  // The strap is sampled by a clock after reset release, never inside reset.
  logic strap_done_ff;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      strap_done_ff <= 1'b0;
      own_addr_o    <= {ITRP_ADDR_HI, ITRP_STRAP_TIE, ITRP_ADDR_LO};
    end else if (!strap_done_ff) begin
      strap_done_ff <= 1'b1;
      own_addr_o    <= {ITRP_ADDR_HI, addr_strap_i, ITRP_ADDR_LO};
    end
  end

  // ==========================================================================
  // Byte engine
  // ==========================================================================
  itrp_state_e state_ff;
  logic [3:0]  bit_ff;
  logic [7:0]  shift_ff;
  logic [7:0]  offs_ff;
  logic        ack_slot;
  logic        addr_match;

  // Bit counter 0..7 are data bits, 8 is the acknowledge slot.
  // A START parks the counter at all ones, so the falling edge that closes the
  // START wraps it to zero instead of being counted as the end of a bit.
  assign ack_slot   = (bit_ff == ITRP_BIT_ACK);
  assign addr_match = (shift_ff[7:1] == own_addr_o);

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      bit_ff <= 4'h0;
    end else if (start_det || stop_det) begin
      bit_ff <= 4'hF;
    end else if (scl_fall && state_ff != ITRP_IDLE && state_ff != ITRP_IGNORE) begin
      bit_ff <= ack_slot ? 4'h0 : bit_ff + 4'h1;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_ff <= 8'h00;
    end else if (scl_rise && !ack_slot) begin
      shift_ff <= {shift_ff[6:0], sda_s};
    end
  end

  // Decisions are taken on the falling edge that ends the eighth bit, so the
  // new state already governs the ninth clock that carries the acknowledge.
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= ITRP_IDLE;
    end else if (stop_det) begin
      state_ff <= ITRP_IDLE;
    end else if (start_det) begin
      state_ff <= ITRP_ADDR;
    end else if (scl_fall && bit_ff == ITRP_BIT_LAST) begin
      unique case (state_ff)
        ITRP_ADDR: begin
          if (!addr_match) begin
            state_ff <= ITRP_IGNORE;
          end else if (shift_ff[0] == ITRP_DIR_READ) begin
            state_ff <= ITRP_RDATA;
          end else begin
            state_ff <= ITRP_OFFS;
          end
        end
        ITRP_OFFS: begin
          state_ff <= ITRP_WDATA;
        end
        default: state_ff <= state_ff;
      endcase
    end else if (scl_rise && ack_slot && state_ff == ITRP_RDATA && sda_s) begin
      state_ff <= ITRP_IGNORE;
    end
  end

  // ==========================================================================
  // Offset counter and register port
  // ==========================================================================
  // Writes outside the map raise no strobe and reads there return 0xFF from
  // here, so the acknowledge never depends on the map.
  logic [7:0] rd_byte;
  assign rd_byte = (offs_ff > ITRP_MAP_LAST) ? ITRP_UNDEF_DATA : rd_data_i;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      offs_ff   <= ITRP_OFFS_RESET;
      wr_stb_o  <= 1'b0;
      wr_offs_o <= ITRP_OFFS_RESET;
      wr_data_o <= 8'h00;
    end else begin
      wr_stb_o <= 1'b0;
      if (scl_fall && bit_ff == ITRP_BIT_LAST) begin
        if (state_ff == ITRP_OFFS) begin
          offs_ff <= shift_ff;
        end else if (state_ff == ITRP_WDATA) begin
          wr_stb_o  <= (offs_ff <= ITRP_MAP_LAST);
          wr_offs_o <= offs_ff;
          wr_data_o <= shift_ff;
          offs_ff   <= offs_ff + 8'h01;
        end
      end else if (scl_fall && ack_slot && state_ff == ITRP_RDATA) begin
        offs_ff <= offs_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_offs_o <= ITRP_OFFS_RESET;
    end else begin
      rd_offs_o <= offs_ff;
    end
  end

  // ==========================================================================
  // Data line driver
  // ==========================================================================
  // Only the data line is ever driven; there is no clock output at all.
  logic [7:0] rd_shift_ff;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sda_o       <= 1'b0;
      sda_oe_o    <= 1'b0;
      rd_shift_ff <= 8'h00;
    end else if (start_det || stop_det) begin
      sda_oe_o <= 1'b0;
      sda_o    <= 1'b0;
    end else if (scl_fall) begin
      sda_o <= 1'b0;
      if (bit_ff == ITRP_BIT_LAST && state_ff == ITRP_ADDR && addr_match) begin
        sda_oe_o <= 1'b1;
        if (shift_ff[0] == ITRP_DIR_READ) begin
          rd_shift_ff <= rd_byte;
        end
      end else if (bit_ff == ITRP_BIT_LAST && (state_ff == ITRP_OFFS || state_ff == ITRP_WDATA)) begin
        sda_oe_o <= 1'b1;
      end else if (state_ff == ITRP_RDATA && !(bit_ff == ITRP_BIT_LAST)) begin
        sda_oe_o    <= ~rd_shift_ff[7];
        rd_shift_ff <= {rd_shift_ff[6:0], 1'b1};
        if (ack_slot) begin
          sda_oe_o    <= ~rd_byte[7];
          rd_shift_ff <= {rd_byte[6:0], 1'b1};
        end
      end else begin
        sda_oe_o <= 1'b0;
      end
    end
  end

endmodule

// ===== sim/itrp_ctrl_model.sv
`timescale 1ns/1ps
module itrp_ctrl_model (
  output logic      scl_o,
  output logic      sda_low_o,
  input  wire logic sda_i
);
  // Slow mode holds the clock low longer, as a stretching target would.
  bit slow = 1'b0;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic start();
    #200 sda_low_o = 1'b0;
    #100 scl_o = 1'b1;
    #200 sda_low_o = 1'b1;
    #200 scl_o = 1'b0;
  endtask
  task automatic stop();
    #200 sda_low_o = 1'b1;
    #100 scl_o = 1'b1;
    #200 sda_low_o = 1'b0;
    #200;
  endtask
  task automatic bitx(input logic b, output logic r);
    #100 sda_low_o = ~b;
    #100 scl_o = 1'b1;
    #200 r = sda_i;
    scl_o = 1'b0;
    if (slow) #200;
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, ack);
  endtask
  task automatic rd(output logic [7:0] d, input logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(nack, r);
  endtask
endmodule

// ===== sim/itrp_target_props.sv
`timescale 1ns/1ps
module itrp_target_props
  import itrp_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       nrst_i,
  input wire logic [1:0] addr_strap_i,
  input wire logic       scl_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic       wr_stb_o,
  input wire logic [7:0] wr_offs_o,
  input wire logic [6:0] own_addr_o
);
  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  AST_ADDR_FIXED: assert property (own_addr_o[6:4] == ITRP_ADDR_HI && own_addr_o[1:0] == ITRP_ADDR_LO)
    else $error("fixed address bits wrong");
  AST_ADDR_STRAP: assert property ($past(nrst_i) |-> own_addr_o[3:2] == addr_strap_i)
    else $error("strap address bits wrong");
  AST_OPEN_DRAIN: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  AST_STB_MAP: assert property (wr_stb_o |-> wr_offs_o <= ITRP_MAP_LAST)
    else $error("strobe beyond register map");
  AST_STB_PULSE: assert property (wr_stb_o |=> !wr_stb_o)
    else $error("strobe longer than one cycle");
  AST_STB_SCL_LOW: assert property (wr_stb_o |-> !scl_i && !$past(scl_i, 2))
    else $error("strobe before byte complete");
  AST_OE_RISE_LOW: assert property ($rose(sda_oe_o) |-> !scl_i)
    else $error("data pulled low while clock high");
  AST_OE_STABLE_HIGH: assert property ($rose(scl_i) |-> $stable(sda_oe_o) [*3])
    else $error("data changed during clock high");
endmodule

bind itrp_target itrp_target_props itrp_target_props_i (.clk_i, .nrst_i, .addr_strap_i, .scl_i, .sda_o,
  .sda_oe_o, .wr_stb_o, .wr_offs_o, .own_addr_o);

// ===== sim/itrp_target_test.sv
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("Error %0t: got %h exp %h", $time, a, b); end end
module itrp_target_test;
  import itrp_pkg::*;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic [1:0] strap = 2'h0;
  wire        scl;
  wire        sda_low;
  wire        sda;
  logic       sda_oe;
  logic       wr_stb;
  logic [7:0] wr_offs;
  logic [7:0] wr_data;
  logic [7:0] rd_offs;
  logic [7:0] rd_data;
  logic [6:0] own;
  logic [7:0] regs [0:31];
  logic [7:0] ref_m [0:31];
  logic [15:0] seed = 16'hDB57;
  int num_errors = 0;
  int total_checks = 0;

  always #25 clk = ~clk;
  // Open-drain line with a pull-up.
  assign sda = !(sda_low | sda_oe);
  // Out-of-map reads see zeros here, so the substitution must happen in the design.
  assign rd_data = (rd_offs <= ITRP_MAP_LAST) ? regs[rd_offs[4:0]] : 8'h00;
  always @(posedge clk) if (wr_stb) regs[wr_offs[4:0]] <= wr_data;

  itrp_target itrp_target_i (.clk_i(clk), .nrst_i(nrst), .addr_strap_i(strap), .scl_i(scl), .sda_i(sda),
    .sda_o(), .sda_oe_o(sda_oe), .wr_stb_o(wr_stb), .wr_offs_o(wr_offs), .wr_data_o(wr_data),
    .rd_offs_o(rd_offs), .rd_data_i(rd_data), .own_addr_o(own));
  itrp_ctrl_model itrp_ctrl_model_i (.scl_o(scl), .sda_low_o(sda_low), .sda_i(sda));

  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction
  function automatic logic [7:0] exp_rd(input logic [7:0] off);
    return (off <= ITRP_MAP_LAST) ? ref_m[off[4:0]] : ITRP_UNDEF_DATA;
  endfunction
  task automatic test_done();
    if (num_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic head(input logic [7:0] off);
    logic ack;
    itrp_ctrl_model_i.start();
    itrp_ctrl_model_i.wr({own, 1'b0}, ack);
    `CHK(ack, 1'b0)
    itrp_ctrl_model_i.wr(off, ack);
    `CHK(ack, 1'b0)
  endtask
  task automatic wr_seq(input logic [7:0] off, input int n);
    logic ack;
    logic [7:0] d;
    head(off);
    for (int i = 0; i < n; i++) begin
      d = rnd();
      itrp_ctrl_model_i.wr(d, ack);
      `CHK(ack, 1'b0)
      if (off <= ITRP_MAP_LAST) ref_m[off[4:0]] = d;
      off++;
    end
    itrp_ctrl_model_i.stop();
  endtask
  task automatic rd_seq(input logic [7:0] off, input int n);
    logic ack;
    logic [7:0] d;
    head(off);
    itrp_ctrl_model_i.start();
    itrp_ctrl_model_i.wr({own, ITRP_DIR_READ}, ack);
    `CHK(ack, 1'b0)
    for (int i = 0; i < n; i++) begin
      itrp_ctrl_model_i.rd(d, i == n - 1);
      `CHK(d, exp_rd(off))
      off++;
    end
    #200 `CHK(sda_oe, 1'b0)
    itrp_ctrl_model_i.stop();
  endtask

  initial begin
    logic ack;
    for (int i = 0; i < 32; i++) begin
      regs[i] = 8'(i * 7 + 3);
      ref_m[i] = 8'(i * 7 + 3);
    end
    for (int s = 0; s < 4; s++) begin
      @(negedge clk);
      strap = s[1:0];
      nrst = 1'b0;
      repeat (3) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      `CHK(own, {ITRP_ADDR_HI, strap, ITRP_ADDR_LO})
      itrp_ctrl_model_i.slow = s[0];
      rd_seq(8'h00, 3);
      itrp_ctrl_model_i.start();
      itrp_ctrl_model_i.wr({ITRP_ADDR_HI, ~strap, ITRP_ADDR_LO, 1'b0}, ack);
      `CHK(ack, 1'b1)
      itrp_ctrl_model_i.wr(8'h00, ack);
      `CHK(ack, 1'b1)
      itrp_ctrl_model_i.stop();
      wr_seq(8'h14, 5);
      rd_seq(8'h13, 6);
      wr_seq(8'hFE, 3);
      rd_seq(8'hFF, 3);
      wr_seq(rnd(), 2);
    end
    test_done();
  end
  initial begin
    repeat (100000) @(posedge clk);
    num_errors++;
    test_done();
  end
endmodule
